// ===== rtl/pdv_top.sv
// Purpose: address decode, interrupt vector map, debug port lock gate
// Assumes: single clock hclk, asynchronous reset hresetn
// Notes:   registers over AHB-Lite, zero wait states, always OKAY
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pdv_top
	import pdv_pkg::*;
(
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 clk_en,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic [15:0]          core_addr,
	output logic      [3:0]           periph_sel,
	output logic                      periph_hit,
	input  wire logic [NUM_SRC-1:0]   src_event,
	input  wire logic [NUM_SRC-1:0]   src_flag_clear,
	output logic      [NUM_VEC-1:0]   vector_req,
	input  wire logic                 dbg_req,
	input  wire logic                 dbg_write,
	input  wire logic [15:0]          dbg_addr,
	input  wire logic                 dbg_cs_space,
	output logic                      dbg_grant,
	output logic                      dbg_refused,
	output logic                      device_locked
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0]        hrdata;
		logic               ready;
		logic               resp;
		logic               dph_valid;
		logic               dph_write;
		logic [11:0]        dph_addr;
		logic [7:0]         lock_key;
		logic               gie;
		logic [NUM_SRC-1:0] flags;
		logic [NUM_SRC-1:0] enables;
		logic [NUM_VEC-1:0] vec;
		logic [3:0]         psel;
		logic               phit;
		logic               grant;
		logic               refused;
		logic               locked;
	} pdv_state_t;

	pdv_state_t state_reg;
	pdv_state_t state_next;

	logic [3:0] dec_sel;
	logic       dec_hit;

	// ------------------------------------------------------------
	// address decoder
	// ------------------------------------------------------------
	pdv_addr_decode u_decode (
		.addr    (core_addr),
		.win_sel (dec_sel),
		.win_hit (dec_hit)
	);

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	function automatic logic [NUM_SRC-1:0] mask_word(
		input logic [31:0] w
	);
		mask_word = w[NUM_SRC-1:0];
	endfunction

	// key check, used by the gate and the locked flag
	function automatic logic key_is_open(
		input logic [7:0] key
	);
		key_is_open = (key == LOCK_OPEN_KEY);
	endfunction

	// debug request allowed: open, or a control and status read
	function automatic logic dbg_allowed(
		input logic        key_ok,
		input logic        cs_space,
		input logic        wr_req,
		input logic [15:0] addr
	);
		logic cs_read;
		cs_read     = cs_space && !wr_req && (addr < DBG_CS_LIMIT);
		dbg_allowed = key_ok || cs_read;
	endfunction

	// flag update: write one clears, pin clears, event sets last
	function automatic logic [NUM_SRC-1:0] flag_update(
		input logic [NUM_SRC-1:0] cur,
		input logic [NUM_SRC-1:0] sw_clr,
		input logic [NUM_SRC-1:0] pin_clr,
		input logic [NUM_SRC-1:0] event_in
	);
		logic [NUM_SRC-1:0] kept;
		kept        = cur & ~sw_clr & ~pin_clr;
		flag_update = kept | event_in;
	endfunction

	// vector map: a pending source raises its mapped vector (sources 5 and 6 share 8), non-NMI sources only with gie
	function automatic logic [NUM_VEC-1:0] vector_map(
		input logic [NUM_SRC-1:0] pend,
		input logic               gie
	);
		logic [NUM_VEC-1:0] v;
		v = '0;
		for (int s = 0; s < NUM_SRC; s++) begin
			if (pend[s] && (s == SRC_NMI || gie)) begin
				v[SRC_VEC[s]] = 1'b1;
			end
		end
		vector_map = v & VEC_ASSIGNED_MASK;
	endfunction

	// read data for one register offset
	function automatic logic [31:0] read_mux(
		input logic [11:0]        ofs,
		input logic [7:0]         key,
		input logic               gie,
		input logic [NUM_SRC-1:0] flags,
		input logic [NUM_SRC-1:0] enables,
		input logic [NUM_VEC-1:0] vec,
		input logic               locked,
		input logic               phit,
		input logic [3:0]         psel
	);
		logic [31:0] rd;
		rd = 32'h0000_0000;
		unique case (ofs)
			OFS_LOCK_KEY: begin
				rd[7:0] = key;
			end
			OFS_GLOBAL_CTRL: begin
				rd[GIE_BIT] = gie;
			end
			OFS_FLAG_STATUS: begin
				rd[NUM_SRC-1:0] = flags;
			end
			OFS_ENABLE_CTRL: begin
				rd[NUM_SRC-1:0] = enables;
			end
			OFS_REQ_STATUS: begin
				rd = vec;
			end
			OFS_DECODE_STATUS: begin
				rd[5]   = locked;
				rd[4]   = phit;
				rd[3:0] = psel;
			end
			default: begin
				rd = 32'h0000_0000;
			end
		endcase
		read_mux = rd;
	endfunction

	typedef struct packed {
		logic key;
		logic gie;
		logic flags;
		logic enables;
	} pdv_wr_t;

	// write strobes for one data phase
	function automatic pdv_wr_t write_decode(
		input logic        valid,
		input logic        wr_req,
		input logic [11:0] ofs
	);
		pdv_wr_t wr;
		wr = '0;
		if (valid && wr_req) begin
			unique case (ofs)
				OFS_LOCK_KEY: begin
					wr.key = 1'b1;
				end
				OFS_GLOBAL_CTRL: begin
					wr.gie = 1'b1;
				end
				OFS_FLAG_STATUS: begin
					wr.flags = 1'b1;
				end
				OFS_ENABLE_CTRL: begin
					wr.enables = 1'b1;
				end
				default: ;
			endcase
		end
		write_decode = wr;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic               is_open;
		logic               take;
		pdv_wr_t            wr;
		logic [NUM_SRC-1:0] sw_clr;
		logic [NUM_SRC-1:0] pend;
		state_next = state_reg;
		is_open    = 1'b0;
		take       = 1'b0;
		wr         = '0;
		sw_clr     = '0;
		pend       = '0;

		// bus handshake, zero wait states, always okay
		state_next.ready = 1'b1;
		state_next.resp  = 1'b0;
		take             = hsel && hready && htrans[1];

		// write data phase
		wr = write_decode(state_reg.dph_valid, state_reg.dph_write, state_reg.dph_addr);
		if (wr.key) begin
			state_next.lock_key = hwdata[7:0];
		end
		if (wr.gie) begin
			state_next.gie = hwdata[GIE_BIT];
		end
		if (wr.enables) begin
			state_next.enables = mask_word(hwdata);
		end
		if (wr.flags) begin
			sw_clr = mask_word(hwdata);
		end

		// interrupt flags, set wins over clear
		state_next.flags = flag_update(
			state_reg.flags,
			sw_clr,
			src_flag_clear,
			src_event
		);

		// address phase capture and read data
		state_next.dph_valid = take;
		state_next.dph_write = hwrite;
		state_next.dph_addr  = haddr[11:0];
		state_next.hrdata    = 32'h0000_0000;
		if (take && !hwrite) begin
			state_next.hrdata = read_mux(
				haddr[11:0],
				state_reg.lock_key,
				state_reg.gie,
				state_reg.flags,
				state_reg.enables,
				state_reg.vec,
				state_reg.locked,
				state_reg.phit,
				state_reg.psel
			);
		end

		// vector requests
		pend           = state_reg.flags & state_reg.enables;
		state_next.vec = vector_map(pend, state_reg.gie);

		// decoder outputs
		state_next.psel = dec_sel;
		state_next.phit = dec_hit;

		// debug port gate, locked flag follows the key in the same edge
		is_open            = key_is_open(state_reg.lock_key);
		state_next.locked  = !key_is_open(state_next.lock_key);
		state_next.grant   = 1'b0;
		state_next.refused = 1'b0;
		if (dbg_req) begin
			if (dbg_allowed(is_open, dbg_cs_space, dbg_write, dbg_addr)) begin
				state_next.grant = 1'b1;
			end else begin
				state_next.refused = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg          <= '0;
			state_reg.lock_key <= LOCK_KEY_RESET;
			state_reg.locked   <= 1'b1;
			state_reg.ready    <= 1'b1;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// bus side
	assign hrdata        = state_reg.hrdata;
	assign hreadyout     = state_reg.ready;
	assign hresp         = state_reg.resp;

	// decoder side
	assign periph_sel    = state_reg.psel;
	assign periph_hit    = state_reg.phit;

	// interrupt side
	assign vector_req    = state_reg.vec;

	// debug side
	assign dbg_grant     = state_reg.grant;
	assign dbg_refused   = state_reg.refused;
	assign device_locked = state_reg.locked;
endmodule
`default_nettype wire

// ===== rtl/pdv_pkg.sv
// Purpose: constants for the peripheral decode and vector map block
// Assumes: 16-bit data-space addresses, 32-bit register bus words
// Notes:   window bases, vector numbers and register offsets
package pdv_pkg;

	// ------------------------------------------------------------
	// lock key
	// ------------------------------------------------------------
	localparam logic [7:0]  LOCK_OPEN_KEY      = 8'hc5;
	localparam logic [7:0]  LOCK_KEY_RESET     = 8'h00;

	// ------------------------------------------------------------
	// register map (byte addresses, index times four)
	// ------------------------------------------------------------
	localparam logic [7:0]  IDX_LOCK_KEY       = 8'h0a;
	localparam logic [11:0] OFS_LOCK_KEY       = 12'h028;
	localparam logic [11:0] OFS_GLOBAL_CTRL    = 12'h040;
	localparam logic [11:0] OFS_FLAG_STATUS    = 12'h044;
	localparam logic [11:0] OFS_ENABLE_CTRL    = 12'h048;
	localparam logic [11:0] OFS_REQ_STATUS     = 12'h04c;
	localparam logic [11:0] OFS_DECODE_STATUS  = 12'h050;
	localparam int          GIE_BIT            = 0;

	// ------------------------------------------------------------
	// peripheral windows
	// ------------------------------------------------------------
	localparam int NUM_WIN = 13;
	localparam logic [15:0] WIN_BASE [NUM_WIN] = '{
		16'h0000, 16'h001c, 16'h0030, 16'h0120, 16'h0140, 16'h0180,
		16'h0800, 16'h0810, 16'h0820, 16'h0a00, 16'h0a40, 16'h0f00,
		16'h1000};
	localparam logic [15:0] WIN_SIZE [NUM_WIN] = '{
		16'h001c, 16'h0014, 16'h0010, 16'h0020, 16'h0040, 16'h0040,
		16'h0010, 16'h0010, 16'h0010, 16'h0040, 16'h0010, 16'h0100,
		16'h0100};
	localparam logic [3:0]  WIN_NONE           = 4'hf;

	// ------------------------------------------------------------
	// interrupt sources and vectors
	// ------------------------------------------------------------
	localparam int NUM_SRC = 20;
	localparam int NUM_VEC = 32;
	localparam logic [4:0] SRC_VEC [NUM_SRC] = '{
		5'd1, 5'd2, 5'd3, 5'd6, 5'd7, 5'd8, 5'd8, 5'd9, 5'd10, 5'd11,
		5'd12, 5'd13, 5'd17, 5'd24, 5'd25, 5'd26, 5'd27, 5'd28, 5'd29,
		5'd30};
	localparam int          SRC_NMI            = 0;
	localparam logic [31:0] VEC_ASSIGNED_MASK  = 32'h7f02_3fce;

	// ------------------------------------------------------------
	// debug port control and status space
	// ------------------------------------------------------------
	localparam logic [15:0] DBG_CS_LIMIT       = 16'h0010;

endpackage

// ===== rtl/pdv_addr_decode.sv
// Purpose: decode a data-space address into one peripheral window
// Assumes: windows do not overlap
// Notes:   no match gives pdv_pkg::WIN_NONE
`timescale 1ns/100ps
`default_nettype none
module pdv_addr_decode
	import pdv_pkg::*;
(
	input  wire logic [15:0] addr,
	output logic      [3:0]  win_sel,
	output logic             win_hit
);
	// ------------------------------------------------------------
	// window match
	// ------------------------------------------------------------
	always_comb begin
		win_sel = WIN_NONE;
		win_hit = 1'b0;
		for (int i = 0; i < NUM_WIN; i++) begin
			if (addr >= WIN_BASE[i] && addr < WIN_BASE[i] + WIN_SIZE[i]) begin
				win_sel = 4'(i);
				win_hit = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/pdv_assertions.sv
// Purpose: lock gate, key and vector checks at pdv_top ports
// Assumes: clk_en held high by the bench
// Notes:   bound from tb_top
`timescale 1ns/100ps
`default_nettype none
module pdv_chk
	import pdv_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] vector_req,
	input wire logic        dbg_req,
	input wire logic        dbg_write,
	input wire logic [15:0] dbg_addr,
	input wire logic        dbg_cs_space,
	input wire logic        dbg_grant,
	input wire logic        dbg_refused,
	input wire logic        device_locked
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence key_wr(bit op);
		htrans[1] && hwrite && haddr == {20'h0_0000, OFS_LOCK_KEY}
		##1 ((hwdata[7:0] == LOCK_OPEN_KEY) == op);
	endsequence
	sequence cs_read;
		dbg_req && dbg_cs_space && !dbg_write && dbg_addr < DBG_CS_LIMIT;
	endsequence
	key_open_a: assert property (key_wr(1) |-> ##[1:3] !device_locked)
		else $error("key c5 did not open");
	key_bad_a: assert property (key_wr(0) |-> ##[1:3] device_locked)
		else $error("bad key did not lock");
	reset_lock_a: assert property ($rose(hresetn) |-> device_locked && !vector_req)
		else $error("not locked after reset");
	grant_open_a: assert property (dbg_req && !device_locked |=> dbg_grant && !dbg_refused)
		else $error("open request not granted");
	refuse_lock_a: assert property (dbg_req && device_locked
		&& !(dbg_cs_space && !dbg_write && dbg_addr < DBG_CS_LIMIT)
		|=> dbg_refused && !dbg_grant)
		else $error("locked request not refused");
	cs_read_a: assert property (cs_read |=> dbg_grant && !dbg_refused)
		else $error("status read refused");
	idle_dbg_a: assert property (!dbg_req |=> !dbg_grant && !dbg_refused)
		else $error("answer without request");
	vec_unused_a: assert property ((vector_req & ~VEC_ASSIGNED_MASK) == 0)
		else $error("unassigned vector raised");
endmodule
`default_nettype wire

// ===== testbench/pdv_periph_model.sv
// Purpose: peripheral side, raises and clears source flags
// Assumes: fire and ack are one-cycle pulses
// Notes:   slow adds one cycle of delay
`timescale 1ns/100ps
`default_nettype none
module pdv_periph_model (
	input  wire logic        hclk,
	input  wire logic        slow,
	input  wire logic [19:0] fire,
	input  wire logic [19:0] ack,
	output logic      [19:0] src_event = '0,
	output logic      [19:0] src_flag_clear = '0
);
	logic [19:0] fire_d = '0, ack_d = '0;
	always_ff @(posedge hclk) begin
		fire_d <= fire;
		ack_d <= ack;
		src_event <= slow ? fire_d : fire;
		src_flag_clear <= slow ? ack_d : ack;
	end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: random and corner tests of pdv_top
// Assumes: zero wait bus, clk_en tied high
// Notes:   expected vectors from own source table
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
	$display("BAD %0t got %h exp %h", $time, a, e); end end
module tb_top
	import pdv_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0;
	logic dbg_req = 0, dbg_write = 0, dbg_cs = 0, hready, hresp, phit, dg, dr, dlock;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, vreq, r;
	logic [1:0] htrans = 0;
	logic [15:0] core_addr = 0, dbg_addr = 0;
	logic [19:0] fire = 0, ack = 0, sev, sclr;
	logic [3:0] psel;
	int n_errors = 0, n_tests = 0;
	localparam logic [15:0] BASE [13] = '{16'h0000, 16'h001c, 16'h0030, 16'h0120,
		16'h0140, 16'h0180, 16'h0800, 16'h0810, 16'h0820, 16'h0a00, 16'h0a40,
		16'h0f00, 16'h1000};
	localparam int VEC [20] = '{1, 2, 3, 6, 7, 8, 8, 9, 10, 11, 12, 13, 17, 24, 25, 26,
		27, 28, 29, 30};
	always #12.5 hclk = ~hclk;
	pdv_top u_pdv_top (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'b010), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .core_addr,
		.periph_sel(psel), .periph_hit(phit), .src_event(sev), .src_flag_clear(sclr),
		.vector_req(vreq), .dbg_req, .dbg_write, .dbg_addr, .dbg_cs_space(dbg_cs),
		.dbg_grant(dg), .dbg_refused(dr), .device_locked(dlock));
	pdv_periph_model u_pdv_periph_model (.hclk, .slow, .fire, .ack, .src_event(sev),
		.src_flag_clear(sclr));
	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, a};
		do @(posedge hclk); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic dbg(input logic w, cs, input logic [15:0] a, input logic g);
		@(posedge hclk);
		{dbg_req, dbg_write, dbg_cs, dbg_addr} <= {1'b1, w, cs, a};
		@(posedge hclk);
		{dbg_req, dbg_addr} <= {1'b0, ~a};
		#1 `CHK({dg, dr}, {g, !g})
	endtask
	function automatic logic [31:0] vexp(logic [19:0] f, en, logic gie);
		vexp = 0;
		for (int s = 0; s < 20; s++) if (f[s] && en[s] && (gie || s == 0)) vexp[VEC[s]] = 1;
	endfunction
	task automatic print_verdict;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#100000 n_errors++;
		print_verdict();
	end
	initial begin
		logic [19:0] f, en, c;
		logic [7:0] k;
		void'($urandom(32'h00f3_5984));
		repeat (20) @(posedge hclk);
		hresetn <= 1;
		bus(0, 32'h28, 0); `CHK(r, 32'h0)
		bus(1, 32'h3c, 32'hffff_ffff); bus(0, 32'h3c, 0); `CHK(r, 32'h0)
		`CHK(hresp, 1'b0)
		for (int i = 0; i < 14; i++) begin
			@(posedge hclk) core_addr <= i < 13 ? BASE[i] + 16'($urandom % 16) : 16'h2000;
			repeat (2) @(posedge hclk);
			#1 `CHK({phit, psel}, i < 13 ? {1'b1, 4'(i)} : {1'b0, WIN_NONE})
		end
		bus(0, 32'h50, 0); `CHK(r, {26'h0, 2'b10, WIN_NONE})
		$display("decode test done");
		for (int i = 0; i < 10; i++) begin
			{f, en, c} = {20'($urandom), 20'($urandom), 20'($urandom)};
			if (i == 0) {f, en} = {20'hf_ffff, 20'hf_ffff};
			bus(1, 32'h44, 32'h000f_ffff);
			bus(1, 32'h48, {12'h000, en});
			bus(1, 32'h40, 32'(i[1]));
			@(posedge hclk) {fire, slow} <= {f, i[0]};
			@(posedge hclk) fire <= 0;
			repeat (5) @(posedge hclk);
			bus(0, 32'h44, 0); `CHK(r[19:0], f)
			#1 `CHK(vreq, vexp(f, en, i[1]))
			bus(0, 32'h4c, 0); `CHK(r, vexp(f, en, i[1]))
			@(posedge hclk) ack <= c;
			@(posedge hclk) ack <= 0;
			repeat (5) @(posedge hclk);
			#1 `CHK(vreq, vexp(f & ~c, en, i[1]))
		end
		$display("vector test done");
		dbg(0, 0, 16'h0100, 0);
		dbg(0, 1, 16'h000f, 1);
		dbg(0, 1, 16'h0010, 0);
		dbg(1, 1, 16'h0004, 0);
		for (int i = 0; i < 6; i++) begin
			k = i[0] ? 8'($urandom) : (i[1] ? 8'hc4 : LOCK_OPEN_KEY);
			bus(1, 32'h28, {24'h0, k}); bus(0, 32'h28, 0); `CHK(r, {24'h0, k})
			repeat (3) @(posedge hclk);
			#1 `CHK(dlock, k != LOCK_OPEN_KEY)
			dbg(1, 0, 16'($urandom), k == 8'hc5);
		end
		$display("lock test done");
		print_verdict();
	end
endmodule
bind pdv_top pdv_chk u_pdv_chk (.hclk, .hresetn, .haddr, .htrans, .hwrite, .hwdata,
	.vector_req, .dbg_req, .dbg_write, .dbg_addr, .dbg_cs_space, .dbg_grant,
	.dbg_refused, .device_locked);
`default_nettype wire
